// *** rtl/crf_core.sv ***
// module: cpu register file with datapath ports and wishbone slave
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - four 16-bit data registers
// - first two data registers split into bytes
// - data pairs form two 32-bit registers
// - two 16-bit address registers as operands
// - address registers pair into 32 bits
// - 16-bit frame base register
// - 20-bit vector table base register
// - 20-bit program counter
// - separate 16-bit user and interrupt stacks
// - stack flag selects active stack pointer
// - 16-bit static base register
// - status flag register is 11 bits
// - carry flag takes alu carry out
// - zero flag set on zero result
// - sign flag set on negative result
// - bank flag picks register bank
// - overflow flag follows alu overflow
module crf_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // operand read ports, data one cycle later
  input wire crf_pkg::crf_sel_t rdSelA,
  input wire crf_pkg::crf_size_t rdSizeA,
  output logic [crf_pkg::LONG_W-1:0] rdDataA_q,
  input wire crf_pkg::crf_sel_t rdSelB,
  input wire crf_pkg::crf_size_t rdSizeB,
  output logic [crf_pkg::LONG_W-1:0] rdDataB_q,
  // operand write port
  input wire logic wrEn,
  input wire crf_pkg::crf_sel_t wrSel,
  input wire crf_pkg::crf_size_t wrSize,
  input wire logic [crf_pkg::LONG_W-1:0] wrData,
  // alu flag update
  input wire crf_pkg::crf_size_t aluSize,
  input wire logic [crf_pkg::LONG_W-1:0] aluResult,
  input wire logic aluCarryEn,
  input wire logic aluCarry,
  input wire logic aluZeroSignEn,
  input wire logic aluOvfEn,
  input wire logic aluOvf,
  // whole flag, program counter and vector base writes
  input wire logic flgWrEn,
  input wire logic [crf_pkg::FLG_W-1:0] flgWrData,
  input wire logic progWrEn,
  input wire logic [crf_pkg::WIDE_W-1:0] progWrData,
  input wire logic vecWrEn,
  input wire logic [crf_pkg::WIDE_W-1:0] vecWrData,
  // state seen by the datapath
  output logic [crf_pkg::FLG_W-1:0] flags_q,
  output logic [crf_pkg::WIDE_W-1:0] progCnt_q,
  output logic [crf_pkg::WIDE_W-1:0] vecBase_q,
  output logic [crf_pkg::WORD_W-1:0] frameBase,
  output logic [crf_pkg::WORD_W-1:0] staticBase_q,
  output logic [crf_pkg::WORD_W-1:0] activeStack,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [crf_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [crf_pkg::LONG_W-1:0] wb_dat_i,
  output logic [crf_pkg::LONG_W-1:0] wb_dat_o,
  output logic wb_ack_o
);
  import crf_pkg::*;

  // ==========================================================
  // storage
  logic [WORD_W-1:0] bankQ [0:SLOTS-1];
  logic [WORD_W-1:0] userStack_q;
  logic [WORD_W-1:0] intStack_q;
  logic ackQ;
  logic [LONG_W-1:0] busRd_q;
  logic bank;
  logic busReq;
  logic busWr;
  logic busBankHit;
  logic [3:0] busSlot;

  // bank flag steers datapath access; the bus maps both banks flat
  assign bank = flags_q[FLG_BANK];

  // slot of a banked entry in the active bank
  function automatic int slot(input int e);
    return bank ? BANK_ENTRIES + e : e;
  endfunction

  // active stack: user when the stack flag is set
  assign activeStack = flags_q[FLG_STACK] ? userStack_q
                                          : intStack_q;
  // spelled out: a function here would not wake on a bank flag change
  // alone, and the frame base would lag the switch
  assign frameBase = bank ? bankQ[BANK_ENTRIES + E_FRAME]
                          : bankQ[E_FRAME];

  // ==========================================================
  // operand read mux
  function automatic logic [LONG_W-1:0] readOp(input crf_sel_t s,
                                               input crf_size_t z);
    logic [WORD_W-1:0] w;
    logic [LONG_W-1:0] r;
    w = '0;
    r = '0;
    case (s)
      SEL_DATA0: w = bankQ[slot(E_DATA0)];
      SEL_DATA1: w = bankQ[slot(E_DATA1)];
      SEL_DATA2: w = bankQ[slot(E_DATA2)];
      SEL_DATA3: w = bankQ[slot(E_DATA3)];
      SEL_ADDR0: w = bankQ[slot(E_ADDR0)];
      SEL_ADDR1: w = bankQ[slot(E_ADDR1)];
      SEL_FRAME: w = bankQ[slot(E_FRAME)];
      SEL_STATIC: w = staticBase_q;
      SEL_STACK: w = activeStack;
      SEL_USTACK: w = userStack_q;
      SEL_ISTACK: w = intStack_q;
      default: w = '0;
    endcase
    r = {16'h0000, w};
    // byte: data0/1 low halves, data2/3 codes mean their upper halves
    if (z == SZ_BYTE)
    begin
      case (s)
        SEL_DATA0: r = {24'h000000, bankQ[slot(E_DATA0)][7:0]};
        SEL_DATA1: r = {24'h000000, bankQ[slot(E_DATA1)][7:0]};
        SEL_DATA2: r = {24'h000000, bankQ[slot(E_DATA0)][15:8]};
        SEL_DATA3: r = {24'h000000, bankQ[slot(E_DATA1)][15:8]};
        default: r = {24'h000000, w[7:0]};
      endcase
    end
    else if (z == SZ_LONG)
    begin
      case (s)
        SEL_DATA0: r = {bankQ[slot(E_DATA2)], bankQ[slot(E_DATA0)]};
        SEL_DATA1: r = {bankQ[slot(E_DATA3)], bankQ[slot(E_DATA1)]};
        SEL_ADDR0: r = {bankQ[slot(E_ADDR1)], bankQ[slot(E_ADDR0)]};
        default: r = {16'h0000, w};
      endcase
    end
    return r;
  endfunction

  // read ports registered so the data outputs come from flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdDataA_q <= '0;
      rdDataB_q <= '0;
    end
    else
    begin
      rdDataA_q <= readOp(rdSelA, rdSizeA);
      rdDataB_q <= readOp(rdSelB, rdSizeB);
    end
  end

  // ==========================================================
  // wishbone slave
  // byte-lane merge of a bus write into an old value
  function automatic logic [LONG_W-1:0] merge(input logic [LONG_W-1:0] o);
    logic [LONG_W-1:0] m;
    m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    return (o & ~m) | (wb_dat_i & m);
  endfunction

  // a request is live while both cycle and strobe stand
  assign busReq = wb_cyc_i && wb_stb_i;
  // writes land at the edge the master sees ack high
  assign busWr = busReq && wb_we_i && ackQ;
  // two flat banks of seven words; the eighth word of each is a hole
  // and misaligned addresses miss, so they read zero
  assign busBankHit = (wb_adr_i[7:6] == 2'b00) && (wb_adr_i[4:2] != 3'h7)
                      && (wb_adr_i[1:0] == 2'b00);
  assign busSlot = wb_adr_i[5] ? 4'(BANK_ENTRIES) + {1'b0, wb_adr_i[4:2]}
                               : {1'b0, wb_adr_i[4:2]};
  // both outputs straight from flops, no decode after them
  assign wb_ack_o = ackQ;
  assign wb_dat_o = busRd_q;

  // one wait state; unmapped reads answer zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ackQ <= 1'b0;
      busRd_q <= '0;
    end
    else
    begin
      ackQ <= busReq && !ackQ;
      busRd_q <= '0;
      if (busReq && !ackQ && !wb_we_i)
      begin
        if (busBankHit)
          busRd_q <= {16'h0000, bankQ[busSlot]};
        else
          case (wb_adr_i)
            OFS_STATIC: busRd_q <= {16'h0000, staticBase_q};
            OFS_USTACK: busRd_q <= {16'h0000, userStack_q};
            OFS_ISTACK: busRd_q <= {16'h0000, intStack_q};
            OFS_VECTOR: busRd_q <= {12'h000, vecBase_q};
            OFS_PROG: busRd_q <= {12'h000, progCnt_q};
            OFS_FLAGS: busRd_q <= {21'h000000, flags_q};
            default: busRd_q <= '0;
          endcase
      end
    end
  end

  // ==========================================================
  // banked registers; a bus write in the same cycle wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < SLOTS; i++)
        bankQ[i] <= RST_WORD;
    end
    else
    begin
      if (wrEn && wrSel <= SEL_FRAME)
      begin
        case (wrSize)
          SZ_BYTE:
          begin
            if (wrSel == SEL_DATA2)
              bankQ[slot(E_DATA0)][15:8] <= wrData[7:0];
            else if (wrSel == SEL_DATA3)
              bankQ[slot(E_DATA1)][15:8] <= wrData[7:0];
            else
              bankQ[slot(int'(wrSel))][7:0] <= wrData[7:0];
          end
          SZ_LONG:
          begin
            if (wrSel == SEL_DATA0 || wrSel == SEL_DATA1)
            begin
              bankQ[slot(int'(wrSel))] <= wrData[15:0];
              bankQ[slot(int'(wrSel) + 2)] <= wrData[31:16];
            end
            else if (wrSel == SEL_ADDR0)
            begin
              bankQ[slot(E_ADDR0)] <= wrData[15:0];
              bankQ[slot(E_ADDR1)] <= wrData[31:16];
            end
            else
              bankQ[slot(int'(wrSel))] <= wrData[15:0];
          end
          default: bankQ[slot(int'(wrSel))] <= wrData[15:0];
        endcase
      end
      if (busWr && busBankHit)
        bankQ[busSlot] <= 16'(merge({16'h0000, bankQ[busSlot]}));
    end
  end

  // ==========================================================
  // static base and both stack pointers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      staticBase_q <= RST_WORD;
      userStack_q <= RST_WORD;
      intStack_q <= RST_WORD;
    end
    else
    begin
      if (wrEn)
        case (wrSel)
          SEL_STATIC: staticBase_q <= wrData[15:0];
          SEL_USTACK: userStack_q <= wrData[15:0];
          SEL_ISTACK: intStack_q <= wrData[15:0];
          SEL_STACK:
          begin
            if (flags_q[FLG_STACK])
              userStack_q <= wrData[15:0];
            else
              intStack_q <= wrData[15:0];
          end
          default: ;
        endcase
      // bus writes last, so they win a same-edge datapath write
      if (busWr && wb_adr_i == OFS_STATIC)
        staticBase_q <= 16'(merge({16'h0000, staticBase_q}));
      if (busWr && wb_adr_i == OFS_USTACK)
        userStack_q <= 16'(merge({16'h0000, userStack_q}));
      if (busWr && wb_adr_i == OFS_ISTACK)
        intStack_q <= 16'(merge({16'h0000, intStack_q}));
    end
  end

  // ==========================================================
  // program counter and vector table base
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      progCnt_q <= RST_WIDE;
      vecBase_q <= RST_WIDE;
    end
    else
    begin
      if (progWrEn)
        progCnt_q <= progWrData;
      if (vecWrEn)
        vecBase_q <= vecWrData;
      if (busWr && wb_adr_i == OFS_PROG)
        progCnt_q <= 20'(merge({12'h000, progCnt_q}));
      if (busWr && wb_adr_i == OFS_VECTOR)
        vecBase_q <= 20'(merge({12'h000, vecBase_q}));
    end
  end

  // ==========================================================
  // flags; alu updates win over a whole-register write
  logic resZero;
  logic resNeg;

  // zero and sign judged at the width of the operation
  always_comb
  begin
    case (aluSize)
      SZ_BYTE:
      begin
        resZero = aluResult[7:0] == 8'h00;
        resNeg = aluResult[7];
      end
      SZ_LONG:
      begin
        resZero = aluResult == 32'h00000000;
        resNeg = aluResult[31];
      end
      default:
      begin
        resZero = aluResult[15:0] == 16'h0000;
        resNeg = aluResult[15];
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      flags_q <= RST_FLG;
    else
    begin
      // debug bit stored as written; software keeps it zero
      if (flgWrEn)
        flags_q <= flgWrData;
      if (busWr && wb_adr_i == OFS_FLAGS)
        flags_q <= 11'(merge({21'h000000, flags_q}));
      if (aluCarryEn)
        flags_q[FLG_CARRY] <= aluCarry;
      if (aluZeroSignEn)
      begin
        flags_q[FLG_ZERO] <= resZero;
        flags_q[FLG_SIGN] <= resNeg;
      end
      if (aluOvfEn)
        flags_q[FLG_OVF] <= aluOvf;
    end
  end
endmodule
`default_nettype wire

// *** rtl/crf_pkg.sv ***
// package: constants and types for the cpu register file
package crf_pkg;
  // ==========================================================
  // widths
  localparam int WORD_W = 16;
  localparam int LONG_W = 32;
  localparam int WIDE_W = 20;
  localparam int FLG_W = 11;
  localparam int ADR_W = 8;
  localparam int BANK_ENTRIES = 7;
  localparam int SLOTS = 2 * BANK_ENTRIES;
  // ==========================================================
  // banked entry indices
  localparam int E_DATA0 = 0;
  localparam int E_DATA1 = 1;
  localparam int E_DATA2 = 2;
  localparam int E_DATA3 = 3;
  localparam int E_ADDR0 = 4;
  localparam int E_ADDR1 = 5;
  localparam int E_FRAME = 6;
  // ==========================================================
  // status flag bit positions
  localparam int FLG_CARRY = 0;
  localparam int FLG_DEBUG = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_SIGN = 3;
  localparam int FLG_BANK = 4;
  localparam int FLG_OVF = 5;
  localparam int FLG_IEN = 6;
  localparam int FLG_STACK = 7;
  // ==========================================================
  // bus byte offsets
  localparam logic [ADR_W-1:0] OFS_BANK0 = 8'h00;
  localparam logic [ADR_W-1:0] OFS_BANK1 = 8'h20;
  localparam logic [ADR_W-1:0] OFS_STATIC = 8'h40;
  localparam logic [ADR_W-1:0] OFS_USTACK = 8'h44;
  localparam logic [ADR_W-1:0] OFS_ISTACK = 8'h48;
  localparam logic [ADR_W-1:0] OFS_VECTOR = 8'h4c;
  localparam logic [ADR_W-1:0] OFS_PROG = 8'h50;
  localparam logic [ADR_W-1:0] OFS_FLAGS = 8'h54;
  // ==========================================================
  // reset values
  localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
  localparam logic [WIDE_W-1:0] RST_WIDE = 20'h00000;
  localparam logic [FLG_W-1:0] RST_FLG = 11'h000;
  // ==========================================================
  // operand size and selector
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} crf_size_t;
  typedef enum logic [3:0] {
    SEL_DATA0, SEL_DATA1, SEL_DATA2, SEL_DATA3,
    SEL_ADDR0, SEL_ADDR1, SEL_FRAME, SEL_STATIC,
    SEL_STACK, SEL_USTACK, SEL_ISTACK
  } crf_sel_t;
endpackage

// *** testbench/crf_core_asserts.sv ***
// checker: port-level properties of the cpu register file
`timescale 1ns/1ps
`default_nettype none
module crf_core_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // datapath side
  input wire logic wrEn,
  input wire crf_pkg::crf_sel_t wrSel,
  input wire crf_pkg::crf_size_t wrSize,
  input wire logic [crf_pkg::LONG_W-1:0] wrData,
  input wire crf_pkg::crf_size_t aluSize,
  input wire logic [crf_pkg::LONG_W-1:0] aluResult,
  input wire logic aluCarryEn,
  input wire logic aluCarry,
  input wire logic aluZeroSignEn,
  input wire logic aluOvfEn,
  input wire logic aluOvf,
  input wire logic flgWrEn,
  input wire logic progWrEn,
  input wire logic [crf_pkg::WIDE_W-1:0] progWrData,
  input wire logic [crf_pkg::FLG_W-1:0] flags_q,
  input wire logic [crf_pkg::WIDE_W-1:0] progCnt_q,
  input wire logic [crf_pkg::WORD_W-1:0] activeStack,
  // bus side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [crf_pkg::LONG_W-1:0] wb_dat_o,
  input wire logic wb_ack_o
);
  import crf_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // bus handshake: one wait state, one-cycle ack
  a_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside ack");
  // ==========================================================
  // flag updates from the alu
  a_carry_take: assert property (
    aluCarryEn |=> flags_q[FLG_CARRY] == $past(aluCarry))
    else $error("carry flag wrong");
  a_carry_hold: assert property (
    !aluCarryEn && !flgWrEn && !(wb_cyc_i && wb_we_i)
    |=> $stable(flags_q[FLG_CARRY]))
    else $error("carry flag changed unprompted");
  a_zero_byte: assert property (
    aluZeroSignEn && aluSize == SZ_BYTE
    |=> flags_q[FLG_ZERO] == ($past(aluResult[7:0]) == 8'h00))
    else $error("zero flag wrong");
  a_sign_word: assert property (
    aluZeroSignEn && aluSize == SZ_WORD
    |=> flags_q[FLG_SIGN] == $past(aluResult[15]))
    else $error("sign flag wrong");
  a_ovf_take: assert property (
    aluOvfEn |=> flags_q[FLG_OVF] == $past(aluOvf))
    else $error("overflow flag wrong");
  // ==========================================================
  // program counter and stack pointer writes
  a_prog_load: assert property (
    progWrEn && !(wb_cyc_i && wb_we_i)
    |=> progCnt_q == $past(progWrData))
    else $error("program counter not loaded");
  a_stack_write: assert property (
    wrEn && wrSel == SEL_STACK && wrSize == SZ_WORD
    && !flgWrEn && !(wb_cyc_i && wb_we_i)
    |=> activeStack == $past(wrData[15:0]))
    else $error("active stack not written");
  c_bus_write: cover property (wb_ack_o && wb_we_i);
  c_alu_long: cover property (aluZeroSignEn && aluSize == SZ_LONG);
  c_bank_one: cover property (flags_q[FLG_BANK]);
endmodule
bind crf_core crf_core_asserts crf_core_asserts_i (.clk(clk), .rst_n(rst_n),
  .wrEn(wrEn), .wrSel(wrSel), .wrSize(wrSize), .wrData(wrData),
  .aluSize(aluSize), .aluResult(aluResult), .aluCarryEn(aluCarryEn),
  .aluCarry(aluCarry), .aluZeroSignEn(aluZeroSignEn), .aluOvfEn(aluOvfEn),
  .aluOvf(aluOvf), .flgWrEn(flgWrEn), .progWrEn(progWrEn),
  .progWrData(progWrData), .flags_q(flags_q), .progCnt_q(progCnt_q),
  .activeStack(activeStack), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

// *** testbench/crf_dp_model.sv ***
// partner: execution datapath driving the operand and flag ports
`timescale 1ns/1ps
`default_nettype none
module crf_dp_model (
  // clock and read data
  input wire logic clk,
  input wire logic [crf_pkg::LONG_W-1:0] rdDataA_q,
  // operand ports
  output var crf_pkg::crf_sel_t rdSelA,
  output var crf_pkg::crf_size_t rdSizeA,
  output var crf_pkg::crf_sel_t rdSelB,
  output var crf_pkg::crf_size_t rdSizeB,
  output logic wrEn,
  output var crf_pkg::crf_sel_t wrSel,
  output var crf_pkg::crf_size_t wrSize,
  output logic [crf_pkg::LONG_W-1:0] wrData,
  // alu and whole-register writes
  output var crf_pkg::crf_size_t aluSize,
  output logic [crf_pkg::LONG_W-1:0] aluResult,
  output logic aluCarryEn,
  output logic aluCarry,
  output logic aluZeroSignEn,
  output logic aluOvfEn,
  output logic aluOvf,
  output logic flgWrEn,
  output logic [crf_pkg::FLG_W-1:0] flgWrData,
  output logic progWrEn,
  output logic [crf_pkg::WIDE_W-1:0] progWrData,
  output logic vecWrEn,
  output logic [crf_pkg::WIDE_W-1:0] vecWrData
);
  import crf_pkg::*;
  // idle values; port b watches the active stack only
  initial
  begin
    {rdSelA, rdSizeA, rdSelB, rdSizeB} = {SEL_DATA0, SZ_WORD, SEL_STACK, SZ_WORD};
    {wrEn, wrSel, wrSize, wrData} = '0;
    {aluSize, aluResult, aluCarryEn, aluCarry, aluZeroSignEn} = '0;
    {aluOvfEn, aluOvf, flgWrEn, flgWrData} = '0;
    {progWrEn, progWrData, vecWrEn, vecWrData} = '0;
  end
  // strobes last one edge, result settled by the falling edge
  task automatic done();
    @(posedge clk);
    {wrEn, flgWrEn, progWrEn, vecWrEn} <= '0;
    {aluCarryEn, aluZeroSignEn, aluOvfEn} <= '0;
    @(negedge clk);
  endtask
  task automatic rd(input crf_sel_t s, input crf_size_t z, output logic [31:0] d);
    @(posedge clk);
    rdSelA <= s;
    rdSizeA <= z;
    @(posedge clk);
    @(negedge clk);
    d = rdDataA_q;
  endtask
  task automatic wr(input crf_sel_t s, input crf_size_t z, input logic [31:0] d);
    @(posedge clk);
    {wrEn, wrSel, wrSize, wrData} <= {1'b1, s, z, d};
    done();
  endtask
  // debug bit never written as one
  task automatic processor_status_flags(input logic [10:0] f);
    @(posedge clk);
    flgWrEn <= 1'b1;
    flgWrData <= f & ~(11'h001 << FLG_DEBUG);
    done();
  endtask
  task automatic alu(input crf_size_t z, input logic [31:0] r, input logic c, o);
    @(posedge clk);
    {aluSize, aluResult, aluCarry, aluOvf} <= {z, r, c, o};
    {aluCarryEn, aluZeroSignEn, aluOvfEn} <= 3'h7;
    done();
  endtask
  task automatic pv(input logic [19:0] p, v);
    @(posedge clk);
    {progWrEn, progWrData, vecWrEn, vecWrData} <= {1'b1, p, 1'b1, v};
    done();
  endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// testbench: bus and datapath sequences with expected values
`timescale 1ns/1ps
`default_nettype none
module tb;
  import crf_pkg::*;
  logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdA, rdB, q, wDat, aluRes;
  crf_sel_t selA, selB, wSel;
  crf_size_t szA, szB, wSz, aSz;
  logic wEn, cEn, cy, zsEn, oEn, ov, fEn, pEn, vEn;
  logic [10:0] fDat, flags_q;
  logic [19:0] pDat, vDat, progCnt_q, vecBase_q;
  logic [15:0] frameBase, staticBase_q, activeStack;
  int failures = 0;
  int tests_run = 0;
  logic [7:0] spOfs [6] = '{OFS_STATIC, OFS_USTACK, OFS_ISTACK, OFS_VECTOR,
    OFS_PROG, OFS_FLAGS};
  logic [31:0] spExp [6] = '{32'h1234, 32'h2345, 32'h3456, 32'h45678,
    32'h56789, 32'h7fd};
  crf_size_t tSz [5] = '{SZ_BYTE, SZ_WORD, SZ_LONG, SZ_LONG, SZ_BYTE};
  logic [31:0] tRes [5] = '{32'h100, 32'h18000, 32'h0, 32'h80000000, 32'h7f};
  logic [10:0] tExp [5] = '{11'h005, 11'h028, 11'h004, 11'h029, 11'h000};
  // ==========================================================
  // design and partner
  crf_core crf_core_i (.clk(clk), .rst_n(rst_n), .rdSelA(selA), .rdSizeA(szA),
    .rdDataA_q(rdA), .rdSelB(selB), .rdSizeB(szB), .rdDataB_q(rdB),
    .wrEn(wEn), .wrSel(wSel), .wrSize(wSz), .wrData(wDat), .aluSize(aSz),
    .aluResult(aluRes),
    .aluCarryEn(cEn), .aluCarry(cy), .aluZeroSignEn(zsEn), .aluOvfEn(oEn),
    .aluOvf(ov), .flgWrEn(fEn), .flgWrData(fDat), .progWrEn(pEn),
    .progWrData(pDat), .vecWrEn(vEn), .vecWrData(vDat), .flags_q(flags_q),
    .progCnt_q(progCnt_q), .vecBase_q(vecBase_q), .frameBase(frameBase),
    .staticBase_q(staticBase_q), .activeStack(activeStack),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  crf_dp_model crf_dp_model_i (.clk(clk), .rdDataA_q(rdA), .rdSelA(selA),
    .rdSizeA(szA), .rdSelB(selB), .rdSizeB(szB), .wrEn(wEn), .wrSel(wSel),
    .wrSize(wSz), .wrData(wDat), .aluSize(aSz), .aluResult(aluRes),
    .aluCarryEn(cEn), .aluCarry(cy), .aluZeroSignEn(zsEn), .aluOvfEn(oEn),
    .aluOvf(ov), .flgWrEn(fEn), .flgWrData(fDat), .progWrEn(pEn),
    .progWrData(pDat), .vecWrEn(vEn), .vecWrData(vDat));
  // ==========================================================
  // helpers
  task automatic stop_test();
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic cycle held until ack is sampled; bounded wait
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, s, d};
    for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++)
      @(posedge clk);
    if (n >= 50)
    begin
      failures++;
      stop_test();
    end
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  // banked slots first, then the single registers
  function automatic logic [7:0] ofs(input int k);
    return (k < 14) ? 8'(k / 7 * 32 + k % 7 * 4) : spOfs[k-14];
  endfunction
  function automatic logic [31:0] ev(input int k);
    return (k < 14) ? 32'(k + 1) * 32'h1111 : spExp[k-14];
  endfunction
  // ==========================================================
  // clock, reset and sequence
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 20; k++)
    begin
      wb(1'b0, ofs(k), 4'hf, 32'h0, q);
      check(q, 32'h0);
    end
    // upper bits set on purpose: they must be dropped; debug kept at zero
    for (int k = 0; k < 20; k++)
      wb(1'b1, ofs(k), 4'hf, ev(k) | ((k < 19) ? 32'hfff00000 : 32'h0), q);
    for (int k = 0; k < 20; k++)
    begin
      wb(1'b0, ofs(k), 4'hf, 32'h0, q);
      check(q, ev(k));
    end
    wb(1'b1, 8'h80, 4'hf, 32'h12345678, q);
    wb(1'b0, 8'h80, 4'hf, 32'h0, q);
    check(q, 32'h0);
    wb(1'b1, 8'h00, 4'h1, 32'h000000ab, q);
    wb(1'b0, 8'h00, 4'hf, 32'h0, q);
    check(q, 32'h11ab);
    // bank one and user stack are active now
    crf_dp_model_i.rd(SEL_DATA0, SZ_WORD, q);
    check(q, 32'h8888);
    crf_dp_model_i.rd(SEL_DATA0, SZ_LONG, q);
    check(q, 32'haaaa8888);
    crf_dp_model_i.rd(SEL_ADDR0, SZ_LONG, q);
    check(q, 32'hddddcccc);
    crf_dp_model_i.rd(SEL_DATA2, SZ_BYTE, q);
    check(q, 32'h88);
    check(32'(frameBase), 32'heeee);
    check(32'(activeStack), 32'h2345);
    crf_dp_model_i.processor_status_flags(11'h002);
    check(32'(flags_q), 32'h0);
    check(32'(frameBase), 32'h7777);
    check(32'(activeStack), 32'h3456);
    crf_dp_model_i.rd(SEL_DATA0, SZ_LONG, q);
    check(q, 32'h333311ab);
    crf_dp_model_i.wr(SEL_DATA3, SZ_BYTE, 32'h5c);
    crf_dp_model_i.rd(SEL_DATA1, SZ_WORD, q);
    check(q, 32'h5c22);
    crf_dp_model_i.wr(SEL_STACK, SZ_WORD, 32'h4242);
    check(32'(activeStack), 32'h4242);
    wb(1'b0, OFS_USTACK, 4'hf, 32'h0, q);
    check(q, 32'h2345);
    check(rdB, 32'h4242);
    check(32'(staticBase_q), 32'h1234);
    for (int i = 0; i < 5; i++)
    begin
      crf_dp_model_i.alu(tSz[i], tRes[i], tExp[i][0], tExp[i][5]);
      check(32'(flags_q), 32'(tExp[i]));
    end
    crf_dp_model_i.pv(20'habcde, 20'h12345);
    check(32'(progCnt_q), 32'habcde);
    check(32'(vecBase_q), 32'h12345);
    // long write into the address pair, read back as one value
    crf_dp_model_i.wr(SEL_ADDR0, SZ_LONG, 32'h87654321);
    crf_dp_model_i.rd(SEL_ADDR0, SZ_LONG, q);
    check(q, 32'h87654321);
    stop_test();
  end
endmodule
`default_nettype wire
